/* rtl/cpuflg_pkg.sv */
// package: register map, field positions and carriers for the cpu status flags block
package cpuflg_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] FLAGS_OFS  = 8'h00;
    localparam logic [7:0] CORE_CONTROL_REGISTER_OFS = 8'h04;
    localparam logic [7:0] INTCN1_OFS = 8'h08;

    // cpu_flags_register bit positions
    localparam int FLG_C   = 0;
    localparam int FLG_Z   = 1;
    localparam int FLG_OV  = 2;
    localparam int FLG_N   = 3;
    localparam int FLG_RA  = 4;
    localparam int FLG_IPL = 5;
    localparam int FLG_DC  = 8;
    // core_control_register priority high bit, interrupt_control_one nesting_disable
    localparam int CORE_CONTROL_REGISTER_IPL3 = 3;
    localparam int INTCN1_NSTD = 15;

    // values after reset, and the highest three-bit priority level
    localparam logic [15:0] FLAGS_RST  = 16'h0000;
    localparam logic        IPL3_RST   = 1'b0;
    localparam logic        NSTD_RST   = 1'b0;
    localparam logic [2:0]  IPL_MAX    = 3'h7;

    // which flags an instruction is defined to affect
    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } cpuflg_mask_t;

    // one datapath operation
    typedef struct packed {
        logic         valid;
        logic         sub;
        logic         byte_op;
        logic         use_carry;
        logic         z_sticky;
        cpuflg_mask_t affect;
        logic [15:0]  opa;
        logic [15:0]  opb;
    } cpuflg_op_t;

    // flags produced by the arithmetic unit
    typedef struct packed {
        logic        dc;
        logic        n;
        logic        ov;
        logic        zero;
        logic        c;
        logic [15:0] result;
    } cpuflg_res_t;

endpackage : cpuflg_pkg

/* rtl/cpuflg_calc.sv */
// arithmetic unit: add or subtract with carry, byte or word, and its flags
`timescale 1ns/1ns
module cpuflg_calc
    import cpuflg_pkg::*;
(
    input  wire cpuflg_pkg::cpuflg_op_t  op_i,
    input  wire logic                    carry_i,
    output      cpuflg_pkg::cpuflg_res_t res_o
);
    import cpuflg_pkg::*;

    // subtraction adds the inverted operand, carry in stands for no borrow
    wire logic [15:0] opb_eff = op_i.sub ? ~op_i.opb : op_i.opb;
    wire logic        cin     = op_i.use_carry ? carry_i : op_i.sub;
    wire logic [16:0] sum_w   = {1'b0, op_i.opa} + {1'b0, opb_eff} + {16'h0000, cin};
    wire logic [8:0]  sum_b   = {1'b0, op_i.opa[7:0]} + {1'b0, opb_eff[7:0]} + {8'h00, cin};
    wire logic [4:0]  sum_h   = {1'b0, op_i.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
    wire logic        a_msb   = op_i.byte_op ? op_i.opa[7] : op_i.opa[15];
    wire logic        b_msb   = op_i.byte_op ? opb_eff[7] : opb_eff[15];
    wire logic [15:0] result  = op_i.byte_op ? {8'h00, sum_w[7:0]} : sum_w[15:0];
    wire logic        r_msb   = op_i.byte_op ? result[7] : result[15];

    assign res_o.result = result;
    assign res_o.dc     = op_i.byte_op ? sum_h[4] : sum_b[8];
    assign res_o.n      = r_msb;
    assign res_o.ov     = (a_msb == b_msb) && (r_msb != a_msb);
    assign res_o.zero   = op_i.byte_op ? (result[7:0] == 8'h00) : (result == 16'h0000);
    assign res_o.c      = op_i.byte_op ? sum_b[8] : sum_w[16];

endmodule : cpuflg_calc

/* rtl/cpuflg_prio.sv */
// priority join: effective four-bit level and user interrupt block
`timescale 1ns/1ns
module cpuflg_prio
    import cpuflg_pkg::*;
(
    input  wire logic [2:0] ipl_i,
    input  wire logic       ipl3_i,
    output      logic [3:0] level_o,
    output      logic       block_o
);
    import cpuflg_pkg::*;

    // high bit adds eight to the binary level
    assign level_o = {ipl3_i, ipl_i};
    assign block_o = ipl3_i || (ipl_i == IPL_MAX);

endmodule : cpuflg_prio

/* rtl/cpuflg_top.sv */
// cpu status flags word with priority level and wishbone register access
// Operation
// - half carry from bit 3 or 7
// - level seven blocks user interrupts
// - priority field is binary, plus eight high
// - control bit 3 is priority msb
// - high priority bit blocks user interrupts
// - nesting disable makes priority field read only, control bit 3 stays writable
// - repeat flag mirrors loop activity, read only
// - negative flag follows result sign
// - overflow flag on wrong sign change
// - zero cleared on nonzero, sticky otherwise (only z_sticky forms hold it; plain forms set it on a zero result)
// - carry flag from carry out of the result msb
// - bits 15 to 9 read zero
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module cpuflg_top
    import cpuflg_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output      logic [31:0]            wb_dat_o,
    output      logic                   wb_ack_o,
    input  wire cpuflg_pkg::cpuflg_op_t op_i,
    input  wire logic                   hw_ipl_we_i,
    input  wire logic [2:0]             hw_ipl_i,
    input  wire logic                   repeat_busy_i,
    output      logic [15:0]            result_o,
    output      logic [15:0]            flags_o,
    output      logic [3:0]             cpu_prio_o,
    output      logic                   user_irq_block_o
);
    import cpuflg_pkg::*;

    // flag and control state
    logic        dc_q;
    logic        n_q;
    logic        ov_q;
    logic        z_q;
    logic        c_q;
    logic        ra_q;
    logic [2:0]  ipl_q;
    logic        ipl3_q;
    logic        nstd_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [15:0] result_q;

    cpuflg_res_t calc;

    cpuflg_calc u_calc (
        .op_i    (op_i),
        .carry_i (c_q),
        .res_o   (calc)
    );

    cpuflg_prio u_prio (
        .ipl_i   (ipl_q),
        .ipl3_i  (ipl3_q),
        .level_o (cpu_prio_o),
        .block_o (user_irq_block_o)
    );

    // register image, unimplemented bits tied low
    wire logic [15:0] flags_img = {7'h00, dc_q, ipl_q, ra_q, n_q, ov_q, z_q, c_q};
    wire logic [15:0] core_control_register_img = {12'h000, ipl3_q, 3'h0};
    wire logic [15:0] intcn1_img = {nstd_q, 15'h0000};

    // bus decode
    wire logic req      = wb_cyc_i && wb_stb_i;
    wire logic sel_flg  = (wb_adr_i == FLAGS_OFS);
    wire logic sel_cor  = (wb_adr_i == CORE_CONTROL_REGISTER_OFS);
    wire logic sel_int  = (wb_adr_i == INTCN1_OFS);
    // a write takes effect on the edge the master sees ack
    wire logic wr_take  = req && wb_we_i && ack_q;
    wire logic wr_flg_l = wr_take && sel_flg && wb_sel_i[0];
    wire logic wr_flg_h = wr_take && sel_flg && wb_sel_i[1];
    wire logic wr_cor   = wr_take && sel_cor && wb_sel_i[0];
    wire logic wr_int   = wr_take && sel_int && wb_sel_i[1];

    wire logic [15:0] rd_mux = sel_flg ? flags_img :
                               sel_cor ? core_control_register_img :
                               sel_int ? intcn1_img : 16'h0000;

    // per-flag update: datapath wins over software in the same cycle
    wire logic upd   = op_i.valid;
    wire logic upd_c = upd && op_i.affect.c;
    wire logic upd_z = upd && op_i.affect.z;
    wire logic upd_v = upd && op_i.affect.ov;
    wire logic upd_n = upd && op_i.affect.n;
    wire logic upd_h = upd && op_i.affect.dc;

    // z_sticky forms only clear zero, plain forms track the result
    wire logic z_next = op_i.z_sticky ? (z_q && calc.zero) : calc.zero;

    // priority field: hardware load first, software only when nesting allowed
    wire logic ipl_sw = wr_flg_l && !nstd_q;

    // bus slave
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else
        begin
            ack_q  <= req && !ack_q;
            rdat_q <= {16'h0000, rd_mux};
        end
    end

    // arithmetic flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            c_q  <= FLAGS_RST[FLG_C];
            z_q  <= FLAGS_RST[FLG_Z];
            ov_q <= FLAGS_RST[FLG_OV];
            n_q  <= FLAGS_RST[FLG_N];
            dc_q <= FLAGS_RST[FLG_DC];
        end
        else
        begin
            if (upd_c)
                c_q <= calc.c;
            else if (wr_flg_l)
                c_q <= wb_dat_i[FLG_C];
            if (upd_z)
                z_q <= z_next;
            else if (wr_flg_l)
                z_q <= wb_dat_i[FLG_Z];
            if (upd_v)
                ov_q <= calc.ov;
            else if (wr_flg_l)
                ov_q <= wb_dat_i[FLG_OV];
            if (upd_n)
                n_q <= calc.n;
            else if (wr_flg_l)
                n_q <= wb_dat_i[FLG_N];
            if (upd_h)
                dc_q <= calc.dc;
            else if (wr_flg_h)
                dc_q <= wb_dat_i[FLG_DC];
        end
    end

    // priority, repeat status and control bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ipl_q  <= FLAGS_RST[FLG_IPL +: 3];
            ra_q   <= FLAGS_RST[FLG_RA];
            ipl3_q <= IPL3_RST;
            nstd_q <= NSTD_RST;
        end
        else
        begin
            if (hw_ipl_we_i)
                ipl_q <= hw_ipl_i;
            else if (ipl_sw)
                ipl_q <= wb_dat_i[FLG_IPL +: 3];
            ra_q <= repeat_busy_i;
            if (wr_cor)
                ipl3_q <= wb_dat_i[CORE_CONTROL_REGISTER_IPL3];
            if (wr_int)
                nstd_q <= wb_dat_i[INTCN1_NSTD];
        end
    end

    // last datapath result
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            result_q <= 16'h0000;
        else if (upd)
            result_q <= calc.result;
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign flags_o  = flags_img;
    assign result_o = result_q;

    // checks
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing one cycle after request");

    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_o[15:9] == 7'h00
            && (!(wb_ack_o && $past(sel_flg)) || wb_dat_o[31:9] == 23'h000000))
        else $error("unimplemented flag bits not zero");

    a_prio_join: assert property (@(posedge clk_i) disable iff (rst_i)
        cpu_prio_o == {ipl3_q, flags_o[FLG_IPL +: 3]})
        else $error("priority level not joined from high bit and field");

    a_block_high: assert property (@(posedge clk_i) disable iff (rst_i)
        ipl3_q |-> user_irq_block_o && cpu_prio_o >= 4'h8)
        else $error("user interrupts open with high priority bit set");

    a_block_seven: assert property (@(posedge clk_i) disable iff (rst_i)
        (flags_o[FLG_IPL +: 3] == 3'h7) |-> user_irq_block_o)
        else $error("user interrupts open at level seven");

    a_block_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ipl3_q && flags_o[FLG_IPL +: 3] != 3'h7) |-> !user_irq_block_o
            && cpu_prio_o == {1'b0, flags_o[FLG_IPL +: 3]})
        else $error("low priority level decoded wrongly");

    a_ipl_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        (nstd_q && !hw_ipl_we_i) |=> $stable(flags_o[FLG_IPL +: 3]))
        else $error("priority field changed while nesting disabled");

    a_ipl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_flg_l && !nstd_q && !hw_ipl_we_i)
            |=> flags_o[FLG_IPL +: 3] == $past(wb_dat_i[FLG_IPL +: 3]))
        else $error("priority field write lost");

    a_repeat_track: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 flags_o[FLG_RA] == $past(repeat_busy_i))
        else $error("repeat flag does not follow loop activity");

    a_carry_word: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd_c && !op_i.byte_op && !op_i.sub && !op_i.use_carry)
            |=> flags_o[FLG_C] == ({1'b0, $past(op_i.opa)} + {1'b0, $past(op_i.opb)} > 17'h0FFFF))
        else $error("carry flag wrong after word add");

    a_half_byte: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd_h && op_i.byte_op && !op_i.sub && !op_i.use_carry)
            |=> flags_o[FLG_DC] == ($past(op_i.opa[3:0]) + $past(op_i.opb[3:0]) > 5'h0F))
        else $error("half carry wrong after byte add");

    a_neg_sign: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd_n && !op_i.byte_op) |=> flags_o[FLG_N] == result_o[15])
        else $error("negative flag disagrees with result sign");

    a_ovf_pos: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd_v && !op_i.byte_op && !op_i.sub && !op_i.use_carry
            && !op_i.opa[15] && !op_i.opb[15]) |=> flags_o[FLG_OV] == result_o[15])
        else $error("overflow flag wrong for two positive operands");

    a_zero_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd_z && op_i.z_sticky && calc.zero) |=> flags_o[FLG_Z] == $past(z_q))
        else $error("sticky zero flag changed on zero result");

    a_zero_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd_z && !calc.zero) |=> !flags_o[FLG_Z])
        else $error("zero flag not cleared on nonzero result");

    a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (upd && !op_i.affect.n && !op_i.affect.c && !wr_flg_l)
            |=> $stable(flags_o[FLG_N]) && $stable(flags_o[FLG_C]))
        else $error("unaffected flag changed");

endmodule : cpuflg_top

/* testbench/tb_cpuflg_top.sv */
// self-checking testbench for the cpu status flags block
`timescale 1ns/1ns
module tb_cpuflg_top;
    import cpuflg_pkg::*;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic        hw_we;
    logic        rpt;
    logic        blk;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [3:0]  prio;
    logic [2:0]  hw_ipl;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [15:0] result;
    logic [15:0] flags;
    cpuflg_op_t  op;
    int          fail_count;
    int          checks;

    cpuflg_top dut (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .wb_cyc_i         (cyc),
        .wb_stb_i         (stb),
        .wb_we_i          (we),
        .wb_adr_i         (adr),
        .wb_sel_i         (sel),
        .wb_dat_i         (wdat),
        .wb_dat_o         (rdat),
        .wb_ack_o         (ack),
        .op_i             (op),
        .hw_ipl_we_i      (hw_we),
        .hw_ipl_i         (hw_ipl),
        .repeat_busy_i    (rpt),
        .result_o         (result),
        .flags_o          (flags),
        .cpu_prio_o       (prio),
        .user_irq_block_o (blk)
    );

    always #2 clk_i = ~clk_i;

    task test_done;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task chk_out(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: port %h expected %h", $time, got, exp);
        end
    endtask : chk_out

    // one classic cycle, held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 16)
        begin
            fail_count++;
            $display("mismatch at %0t: no ack", $time);
            test_done();
        end
        #1;
    endtask : wb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hF, 32'h0000_0000);
        checks++;
        if (q !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: read %h expected %h", $time, q, exp);
        end
    endtask : rd_chk

    task opchk(input logic s, input logic b, input logic uc, input logic zs, input logic [4:0] af,
               input logic [15:0] a, input logic [15:0] bb, input logic [15:0] er,
               input logic [15:0] ef);
        @(posedge clk_i);
        op <= cpuflg_op_t'({1'b1, s, b, uc, zs, af, a, bb});
        @(posedge clk_i);
        op.valid <= 1'b0;
        #1;
        chk_out(result, er);
        chk_out(flags, ef);
    endtask : opchk

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        op = '0;
        hw_we = 1'b0;
        hw_ipl = 3'h0;
        rpt = 1'b0;
        fail_count = 0;
        checks = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_out(flags, FLAGS_RST);
        chk_out({12'h000, prio, 3'h0, blk}, 16'h0000);
        rd_chk(FLAGS_OFS, 32'h0000_0000);
        rd_chk(CORE_CONTROL_REGISTER_OFS, 32'h0000_0000);
        rd_chk(INTCN1_OFS, 32'h0000_0000);
        $display("test reset done");
        opchk(0, 0, 0, 0, 5'h1F, 16'h7FFF, 16'h0001, 16'h8000, 16'h010C);
        opchk(0, 1, 0, 0, 5'h1F, 16'h000F, 16'h0001, 16'h0010, 16'h0100);
        opchk(0, 1, 0, 0, 5'h1F, 16'h127F, 16'h0001, 16'h0080, 16'h010C);
        opchk(0, 1, 0, 0, 5'h1F, 16'h1280, 16'h3480, 16'h0000, 16'h0007);
        opchk(0, 0, 0, 0, 5'h01, 16'h0001, 16'h0001, 16'h0002, 16'h0006);
        opchk(0, 0, 0, 1, 5'h1F, 16'h0000, 16'h0000, 16'h0000, 16'h0002);
        opchk(0, 0, 0, 1, 5'h1F, 16'h0001, 16'h0001, 16'h0002, 16'h0000);
        opchk(0, 0, 0, 1, 5'h1F, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        opchk(1, 0, 0, 0, 5'h1F, 16'h0005, 16'h0005, 16'h0000, 16'h0103);
        opchk(0, 0, 1, 0, 5'h1F, 16'h0001, 16'h0001, 16'h0003, 16'h0000);
        opchk(1, 0, 0, 0, 5'h1F, 16'h0003, 16'h0005, 16'hFFFE, 16'h0008);
        $display("test datapath done");
        wb(1, FLAGS_OFS, 4'h3, 32'hFFFF_FFFF);
        chk_out(flags, 16'h01EF);
        rd_chk(FLAGS_OFS, 32'h0000_01EF);
        chk_out({12'h000, prio}, 16'h0007);
        chk_out({15'h0000, blk}, 16'h0001);
        wb(1, FLAGS_OFS, 4'h2, 32'h0000_0000);
        chk_out(flags, 16'h00EF);
        wb(1, FLAGS_OFS, 4'h1, 32'h0000_0000);
        chk_out(flags, 16'h0000);
        $display("test register done");
        for (int v = 0; v < 8; v++)
            for (int h = 0; h < 2; h++)
            begin
                wb(1, CORE_CONTROL_REGISTER_OFS, 4'h1, {28'h0, h[0], 3'h0});
                wb(1, FLAGS_OFS, 4'h1, {24'h0, v[2:0], 5'h00});
                chk_out({12'h000, prio}, {12'h000, h[0], v[2:0]});
                chk_out({15'h0000, blk}, {15'h0000, h == 1 || v == 7});
            end
        rd_chk(CORE_CONTROL_REGISTER_OFS, 32'h0000_0008);
        wb(1, CORE_CONTROL_REGISTER_OFS, 4'h1, 32'h0000_0000);
        $display("test priority done");
        wb(1, INTCN1_OFS, 4'h3, 32'h0000_8000);
        rd_chk(INTCN1_OFS, 32'h0000_8000);
        wb(1, FLAGS_OFS, 4'h1, 32'h0000_0061);
        chk_out(flags, 16'h00E1);
        @(posedge clk_i);
        hw_we <= 1'b1;
        hw_ipl <= 3'h2;
        @(posedge clk_i);
        hw_we <= 1'b0;
        #1;
        chk_out(flags, 16'h0041);
        wb(1, INTCN1_OFS, 4'h3, 32'h0000_0000);
        wb(1, FLAGS_OFS, 4'h1, 32'h0000_0061);
        chk_out(flags, 16'h0061);
        $display("test nesting done");
        @(posedge clk_i);
        rpt <= 1'b1;
        @(posedge clk_i);
        #1;
        chk_out(flags, 16'h0071);
        wb(1, FLAGS_OFS, 4'h1, 32'h0000_0001);
        chk_out(flags, 16'h0011);
        @(posedge clk_i);
        rpt <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_out(flags, 16'h0001);
        wb(1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h0C, 32'h0000_0000);
        rd_chk(FLAGS_OFS, 32'h0000_0001);
        $display("test repeat and unmapped done");
        test_done();
    end
endmodule : tb_cpuflg_top
